// [rtl/dsprc_defines.svh]
// dsprc_defines.svh: offsets, field positions, reset value and timing counts
// of the processor runtime control block; definitions only, included by name
`ifndef DSPRC_DEFINES_SVH
`define DSPRC_DEFINES_SVH

// register offsets inside the 256-byte control block
`define DSPRC_OFS_PORTB_PIN_INPUT 8'h01
`define DSPRC_OFS_PORTB_PIN_OUTPUT 8'h05
`define DSPRC_OFS_PORTB_PIN_DIRECTION 8'h07
`define DSPRC_OFS_PORTB_DRIVE_SELECT 8'h09
`define DSPRC_OFS_PORTB_INPUT_CELLS 8'h0b
`define DSPRC_OFS_PORTB_OE_STATE 8'h0d
`define DSPRC_OFS_PORTC_PIN_INPUT 8'h10
`define DSPRC_OFS_PORTD_PIN_INPUT 8'h11
`define DSPRC_OFS_PORTC_PIN_OUTPUT 8'h12
`define DSPRC_OFS_PORTD_PIN_OUTPUT 8'h13
`define DSPRC_OFS_PORTC_PIN_DIRECTION 8'h14
`define DSPRC_OFS_PORTD_PIN_DIRECTION 8'h15
`define DSPRC_OFS_PORTC_DRIVE_SELECT 8'h16
`define DSPRC_OFS_PORTD_DRIVE_SELECT 8'h17
`define DSPRC_OFS_PORTC_INPUT_CELLS 8'h18
`define DSPRC_OFS_PORTC_OE_STATE 8'h1a
`define DSPRC_OFS_PORTD_OE_STATE 8'h1b
`define DSPRC_OFS_OUTPUT_CELLS_AB 8'h20
`define DSPRC_OFS_OUTPUT_CELLS_BC 8'h21
`define DSPRC_OFS_CELL_MASK_AB 8'h22
`define DSPRC_OFS_CELL_MASK_BC 8'h23
`define DSPRC_OFS_POWER_CONTROL_0 8'hb0
`define DSPRC_OFS_POWER_CONTROL_2 8'hb4
`define DSPRC_OFS_SECTOR_PROTECT 8'hc0
`define DSPRC_OFS_SECURITY 8'hc2
`define DSPRC_OFS_TEST_PORT_ENABLE 8'hc7
`define DSPRC_OFS_MEMORY_PAGE 8'he0

// every control register clears to this value
`define DSPRC_REG_RESET 8'h00

// flash command bytes and unlock addresses (low twelve address bits)
`define DSPRC_UNLOCK_ADDR_A 12'h555
`define DSPRC_UNLOCK_ADDR_B 12'haaa
`define DSPRC_CMD_UNLOCK_A 8'haa
`define DSPRC_CMD_UNLOCK_B 8'h55
`define DSPRC_CMD_PROGRAM 8'ha0
`define DSPRC_CMD_ERASE_SETUP 8'h80
`define DSPRC_CMD_BULK_ERASE 8'h10
`define DSPRC_CMD_SECTOR_ERASE 8'h30
`define DSPRC_CMD_READ_ID 8'h90
`define DSPRC_CMD_RESET 8'hf0

// status byte fields while busy
`define DSPRC_STAT_POLL_BIT 7
`define DSPRC_STAT_TOGGLE_BIT 6

// timing: figures in ns, cycle counts derived at the 25 ns clock
`define DSPRC_CLK_PERIOD_NS 25
`define DSPRC_PROG_TIME_NS 10000
`define DSPRC_PROG_CYCLES ((`DSPRC_PROG_TIME_NS + `DSPRC_CLK_PERIOD_NS - 1) / `DSPRC_CLK_PERIOD_NS)
`define DSPRC_ERASE_WINDOW_NS 80000
`define DSPRC_ERASE_WINDOW_CYCLES (`DSPRC_ERASE_WINDOW_NS / `DSPRC_CLK_PERIOD_NS)

`endif

// [rtl/dsprc_pkg.sv]
// dsprc_pkg: types of the processor runtime control block
// assumes the defines header is compiled alongside; holds types only
package dsprc_pkg;

    // processor bus as seen at the pins, strobes active low
    typedef struct packed {
        logic [17:0] addr;
        logic [15:0] wdata;
        logic rd_n;
        logic wr_n;
        logic ioms_n;
        logic dms_n;
        logic bms_n;
    } dsprc_bus_t;

    // one eight-pin port towards its pads
    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe_n;
        logic [7:0] drive_sel;
    } dsprc_port_t;

    typedef enum logic [3:0] {
        FL_READ,
        FL_UNLOCK1,
        FL_UNLOCK2,
        FL_PROG_DATA,
        FL_ERASE_U1,
        FL_ERASE_U2,
        FL_ERASE_U3,
        FL_ERASE_COLLECT,
        FL_ID,
        FL_BUSY_PROG,
        FL_BUSY_ERASE
    } dsprc_flash_st_t;

    // complete register state of the block
    typedef struct packed {
        logic [7:0] pb_out;
        logic [7:0] pc_out;
        logic [7:0] pd_out;
        logic [7:0] pb_dir;
        logic [7:0] pc_dir;
        logic [7:0] pd_dir;
        logic [7:0] pb_ds;
        logic [7:0] pc_ds;
        logic [7:0] pd_ds;
        logic [7:0] cells_ab;
        logic [7:0] cells_bc;
        logic [7:0] mask_ab;
        logic [7:0] mask_bc;
        logic [7:0] pm0;
        logic [7:0] pm2;
        logic [7:0] test_en;
        logic [7:0] page;
        dsprc_flash_st_t fl_st;
        logic [31:0] cnt;
        logic [7:0] erase_sel;
        logic [16:0] prog_addr;
        logic [7:0] prog_data;
        logic toggle;
        logic wr_q;
        logic [7:0] rdata;
        logic rd_valid;
    } dsprc_state_t;

endpackage : dsprc_pkg

// [rtl/dsprc_top.sv]
// dsprc_top: runtime control registers and byte-wide flash of a processor
// companion chip. assumes all bus inputs are synchronous to clk_i and a write
// strobe stays low at least one clock; the upper data byte is never used.
//
// Functional notes
// - decode 256 locations, 27 real registers
// - byte registers in i/o space, upper byte ignored
// - all control registers clear on reset
// - pin input registers show pin levels, read-only
// - output registers drive pins and read back
// - direction bit one drives, zero receives
// - drive select picks open drain or slew
// - input cell registers are read-only state
// - enable-out registers report driver enables, read-only
// - output cell banks read outputs, writes load
// - mask bit one blocks cell read/write
// - sector protect register reports protection, read-only
// - security register reads one when secured
// - test port enable register drives pin enable
// - two power registers read and write
// - page register feeds overlay sector decode
// - eight 16k sectors, individually protectable
// - one select per sector, two terms (dma and overlay)
// - ready/busy low during program or erase
// - dma and overlay accesses both byte operations
// - read-array mode returns stored bytes
// - control block needs i/o strobe only, low 256
`include "dsprc_defines.svh"

module dsprc_top
    import dsprc_pkg::*;
#(
    parameter int ERASE_WINDOW_CYCLES = `DSPRC_ERASE_WINDOW_CYCLES,
    parameter int PROG_CYCLES = `DSPRC_PROG_CYCLES,
    parameter logic [7:0] FLASH_ID = 8'h5a // arbitrary identifier value
)
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire dsprc_pkg::dsprc_bus_t bus_i,
    output logic [7:0] rdata_o,
    output logic rdata_oe_o,
    input wire logic [7:0] pb_pins_i,
    input wire logic [7:0] pc_pins_i,
    input wire logic [7:0] pd_pins_i,
    output dsprc_pkg::dsprc_port_t pb_o,
    output dsprc_pkg::dsprc_port_t pc_o,
    output dsprc_pkg::dsprc_port_t pd_o,
    input wire logic [7:0] input_cell_b_i,
    input wire logic [7:0] input_cell_c_i,
    output logic [7:0] output_cell_ab_o,
    output logic [7:0] output_cell_bc_o,
    input wire logic [7:0] sector_protect_i,
    input wire logic secured_i,
    output logic [7:0] power_control_0_o,
    output logic [7:0] power_control_2_o,
    output logic test_port_pin_enable_o,
    output logic [7:0] flash_sector_selects_o,
    output logic ready_busy_pin_o
);

    localparam int SWEEP = 1 << 17;

    if (PROG_CYCLES < 1 || ERASE_WINDOW_CYCLES < 1)
        $error("dsprc_top: timing counts must be at least one cycle");

    dsprc_state_t st;
    dsprc_state_t next_st;
    logic [7:0] mem [0:SWEEP-1];
    logic [7:0] mem_rd;
    logic csiop_sel;
    logic [7:0] fsel;
    logic [16:0] fl_addr;
    logic wr_start;
    logic rd_act;
    logic [7:0] wd;
    logic [11:0] lo;
    logic prog_commit;
    logic erase_write;

    ////////////////////////////////////////////////////////////////////////////
    // address decode

    // control block needs only the i/o strobe, within the low 256 bytes
    assign csiop_sel = !bus_i.ioms_n && bus_i.dms_n && bus_i.bms_n
        && bus_i.addr[17:8] == 10'h000;

    // each sector select is the or of a dma term and an overlay term
    always_comb
    begin
        for (int s = 0; s < 8; s++)
        begin
            fsel[s] = (bus_i.ioms_n && bus_i.dms_n && !bus_i.bms_n
                    && !bus_i.addr[17] && bus_i.addr[16:14] == 3'(s))
                || (bus_i.ioms_n && !bus_i.dms_n && bus_i.bms_n
                    && bus_i.addr[17:14] == 4'h0
                    && st.page == 8'(s));
        end
    end

    // dma uses the linear address, overlay the page plus the 16k window
    assign fl_addr = !bus_i.bms_n ? bus_i.addr[16:0]
        : {st.page[2:0], bus_i.addr[13:0]};
    assign flash_sector_selects_o = fsel;

    // only the low data byte counts; a write is taken once per strobe
    assign wd = bus_i.wdata[7:0];
    assign lo = bus_i.addr[11:0];
    assign wr_start = !bus_i.wr_n && st.wr_q;
    assign rd_act = !bus_i.rd_n;

    ////////////////////////////////////////////////////////////////////////////
    // flash array: program ands bits in, erase sweeps one byte a clock

    assign prog_commit = st.fl_st == FL_BUSY_PROG && st.cnt == 32'(PROG_CYCLES - 1);
    assign erase_write = st.fl_st == FL_BUSY_ERASE
        && st.erase_sel[st.cnt[16:14]];

    always_ff @(posedge clk_i)
    begin
        if (prog_commit)
            mem[st.prog_addr] <= mem[st.prog_addr] & st.prog_data;
        else if (erase_write)
            mem[st.cnt[16:0]] <= 8'hff;
    end
    assign mem_rd = mem[fl_addr];

    ////////////////////////////////////////////////////////////////////////////
    // next state: registers, flash sequencer, read data

    always_comb
    begin
        next_st = st;
        next_st.wr_q = bus_i.wr_n;
        next_st.rd_valid = rd_act && (csiop_sel || |fsel);
        // register writes; read-only and unused offsets fall through
        if (wr_start && csiop_sel)
        begin
            if (bus_i.addr[7:0] == `DSPRC_OFS_PORTB_PIN_OUTPUT)
                next_st.pb_out = wd;
            else if (bus_i.addr[7:0] == `DSPRC_OFS_PORTC_PIN_OUTPUT)
                next_st.pc_out = wd;
            else if (bus_i.addr[7:0] == `DSPRC_OFS_PORTD_PIN_OUTPUT)
                next_st.pd_out = wd;
            else if (bus_i.addr[7:0] == `DSPRC_OFS_PORTB_PIN_DIRECTION)
                next_st.pb_dir = wd;
            else if (bus_i.addr[7:0] == `DSPRC_OFS_PORTC_PIN_DIRECTION)
                next_st.pc_dir = wd;
            else if (bus_i.addr[7:0] == `DSPRC_OFS_PORTD_PIN_DIRECTION)
                next_st.pd_dir = wd;
            else if (bus_i.addr[7:0] == `DSPRC_OFS_PORTB_DRIVE_SELECT)
                next_st.pb_ds = wd;
            else if (bus_i.addr[7:0] == `DSPRC_OFS_PORTC_DRIVE_SELECT)
                next_st.pc_ds = wd;
            else if (bus_i.addr[7:0] == `DSPRC_OFS_PORTD_DRIVE_SELECT)
                next_st.pd_ds = wd;
            else if (bus_i.addr[7:0] == `DSPRC_OFS_OUTPUT_CELLS_AB)
                next_st.cells_ab = (st.cells_ab & st.mask_ab)
                    | (wd & ~st.mask_ab);
            else if (bus_i.addr[7:0] == `DSPRC_OFS_OUTPUT_CELLS_BC)
                next_st.cells_bc = (st.cells_bc & st.mask_bc)
                    | (wd & ~st.mask_bc);
            else if (bus_i.addr[7:0] == `DSPRC_OFS_CELL_MASK_AB)
                next_st.mask_ab = wd;
            else if (bus_i.addr[7:0] == `DSPRC_OFS_CELL_MASK_BC)
                next_st.mask_bc = wd;
            else if (bus_i.addr[7:0] == `DSPRC_OFS_POWER_CONTROL_0)
                next_st.pm0 = wd;
            else if (bus_i.addr[7:0] == `DSPRC_OFS_POWER_CONTROL_2)
                next_st.pm2 = wd;
            else if (bus_i.addr[7:0] == `DSPRC_OFS_TEST_PORT_ENABLE)
                next_st.test_en = wd;
            else if (bus_i.addr[7:0] == `DSPRC_OFS_MEMORY_PAGE)
                next_st.page = wd;
            // other offsets: no effect at all
        end

        // flash command sequencer; a wrong byte drops back to read array, except in the erase window and the two busy states, which ignore it
        next_st.cnt = st.cnt + 32'd1;
        case (st.fl_st)
            FL_READ, FL_ID:
            begin
                if (wr_start && |fsel)
                begin
                    if (wd == `DSPRC_CMD_UNLOCK_A && lo == `DSPRC_UNLOCK_ADDR_A)
                        next_st.fl_st = FL_UNLOCK1;
                    else
                        next_st.fl_st = FL_READ;
                end
            end
            FL_UNLOCK1:
            begin
                if (wr_start && |fsel)
                    next_st.fl_st = (wd == `DSPRC_CMD_UNLOCK_B
                        && lo == `DSPRC_UNLOCK_ADDR_B) ? FL_UNLOCK2 : FL_READ;
            end
            FL_UNLOCK2:
            begin
                if (wr_start && |fsel)
                begin
                    if (lo != `DSPRC_UNLOCK_ADDR_A)
                        next_st.fl_st = FL_READ;
                    else if (wd == `DSPRC_CMD_PROGRAM)
                        next_st.fl_st = FL_PROG_DATA;
                    else if (wd == `DSPRC_CMD_ERASE_SETUP)
                        next_st.fl_st = FL_ERASE_U1;
                    else if (wd == `DSPRC_CMD_READ_ID)
                        next_st.fl_st = FL_ID;
                    else
                        next_st.fl_st = FL_READ;
                end
            end
            FL_PROG_DATA:
            begin
                // protected sectors take the byte but never program it
                if (wr_start && |fsel)
                begin
                    next_st.prog_addr = fl_addr;
                    next_st.prog_data = wd;
                    next_st.cnt = 32'd0;
                    next_st.fl_st = sector_protect_i[fl_addr[16:14]]
                        ? FL_READ : FL_BUSY_PROG;
                end
            end
            FL_ERASE_U1:
            begin
                if (wr_start && |fsel)
                    next_st.fl_st = (wd == `DSPRC_CMD_UNLOCK_A
                        && lo == `DSPRC_UNLOCK_ADDR_A) ? FL_ERASE_U2 : FL_READ;
            end
            FL_ERASE_U2:
            begin
                if (wr_start && |fsel)
                    next_st.fl_st = (wd == `DSPRC_CMD_UNLOCK_B
                        && lo == `DSPRC_UNLOCK_ADDR_B) ? FL_ERASE_U3 : FL_READ;
            end
            FL_ERASE_U3:
            begin
                if (wr_start && |fsel)
                begin
                    next_st.cnt = 32'd0;
                    next_st.erase_sel = 8'h00;
                    next_st.fl_st = FL_READ;
                    if (wd == `DSPRC_CMD_BULK_ERASE && lo == `DSPRC_UNLOCK_ADDR_A)
                    begin
                        next_st.erase_sel = ~sector_protect_i;
                        next_st.fl_st = FL_BUSY_ERASE;
                    end
                    else if (wd == `DSPRC_CMD_SECTOR_ERASE)
                    begin
                        next_st.erase_sel = fsel & ~sector_protect_i;
                        next_st.fl_st = FL_ERASE_COLLECT;
                    end
                end
            end
            FL_ERASE_COLLECT:
            begin
                // further sectors may join until the window runs out
                if (wr_start && |fsel && wd == `DSPRC_CMD_SECTOR_ERASE)
                begin
                    next_st.erase_sel = st.erase_sel | (fsel & ~sector_protect_i);
                    next_st.cnt = 32'd0;
                end
                else if (st.cnt >= 32'(ERASE_WINDOW_CYCLES - 1))
                begin
                    next_st.cnt = 32'd0;
                    next_st.fl_st = FL_BUSY_ERASE;
                end
            end
            FL_BUSY_PROG:
            begin
                if (prog_commit)
                    next_st.fl_st = FL_READ;
            end
            FL_BUSY_ERASE:
            begin
                if (st.cnt == 32'(SWEEP - 1))
                    next_st.fl_st = FL_READ;
            end
            default:
                next_st.fl_st = FL_READ;
        endcase
        // a reset command leaves any mode that is not busy
        if (wr_start && |fsel && wd == `DSPRC_CMD_RESET
            && st.fl_st != FL_BUSY_PROG && st.fl_st != FL_BUSY_ERASE)
            next_st.fl_st = FL_READ;

        // read data is captured on the same edge that samples the strobe low
        next_st.rdata = 8'h00;
        if (rd_act && csiop_sel)
        begin
            if (bus_i.addr[7:0] == `DSPRC_OFS_PORTB_PIN_INPUT)
                next_st.rdata = pb_pins_i;
            else if (bus_i.addr[7:0] == `DSPRC_OFS_PORTC_PIN_INPUT)
                next_st.rdata = pc_pins_i;
            else if (bus_i.addr[7:0] == `DSPRC_OFS_PORTD_PIN_INPUT)
                next_st.rdata = pd_pins_i;
            else if (bus_i.addr[7:0] == `DSPRC_OFS_PORTB_PIN_OUTPUT)
                next_st.rdata = st.pb_out;
            else if (bus_i.addr[7:0] == `DSPRC_OFS_PORTC_PIN_OUTPUT)
                next_st.rdata = st.pc_out;
            else if (bus_i.addr[7:0] == `DSPRC_OFS_PORTD_PIN_OUTPUT)
                next_st.rdata = st.pd_out;
            else if (bus_i.addr[7:0] == `DSPRC_OFS_PORTB_PIN_DIRECTION)
                next_st.rdata = st.pb_dir;
            else if (bus_i.addr[7:0] == `DSPRC_OFS_PORTC_PIN_DIRECTION)
                next_st.rdata = st.pc_dir;
            else if (bus_i.addr[7:0] == `DSPRC_OFS_PORTD_PIN_DIRECTION)
                next_st.rdata = st.pd_dir;
            else if (bus_i.addr[7:0] == `DSPRC_OFS_PORTB_DRIVE_SELECT)
                next_st.rdata = st.pb_ds;
            else if (bus_i.addr[7:0] == `DSPRC_OFS_PORTC_DRIVE_SELECT)
                next_st.rdata = st.pc_ds;
            else if (bus_i.addr[7:0] == `DSPRC_OFS_PORTD_DRIVE_SELECT)
                next_st.rdata = st.pd_ds;
            else if (bus_i.addr[7:0] == `DSPRC_OFS_PORTB_INPUT_CELLS)
                next_st.rdata = input_cell_b_i;
            else if (bus_i.addr[7:0] == `DSPRC_OFS_PORTC_INPUT_CELLS)
                next_st.rdata = input_cell_c_i;
            else if (bus_i.addr[7:0] == `DSPRC_OFS_PORTB_OE_STATE)
                next_st.rdata = ~pb_o.oe_n;
            else if (bus_i.addr[7:0] == `DSPRC_OFS_PORTC_OE_STATE)
                next_st.rdata = ~pc_o.oe_n;
            else if (bus_i.addr[7:0] == `DSPRC_OFS_PORTD_OE_STATE)
                next_st.rdata = ~pd_o.oe_n;
            else if (bus_i.addr[7:0] == `DSPRC_OFS_OUTPUT_CELLS_AB)
                next_st.rdata = st.cells_ab & ~st.mask_ab;
            else if (bus_i.addr[7:0] == `DSPRC_OFS_OUTPUT_CELLS_BC)
                next_st.rdata = st.cells_bc & ~st.mask_bc;
            else if (bus_i.addr[7:0] == `DSPRC_OFS_CELL_MASK_AB)
                next_st.rdata = st.mask_ab;
            else if (bus_i.addr[7:0] == `DSPRC_OFS_CELL_MASK_BC)
                next_st.rdata = st.mask_bc;
            else if (bus_i.addr[7:0] == `DSPRC_OFS_POWER_CONTROL_0)
                next_st.rdata = st.pm0;
            else if (bus_i.addr[7:0] == `DSPRC_OFS_POWER_CONTROL_2)
                next_st.rdata = st.pm2;
            else if (bus_i.addr[7:0] == `DSPRC_OFS_SECTOR_PROTECT)
                next_st.rdata = sector_protect_i;
            else if (bus_i.addr[7:0] == `DSPRC_OFS_SECURITY)
                next_st.rdata = {7'h00, secured_i};
            else if (bus_i.addr[7:0] == `DSPRC_OFS_TEST_PORT_ENABLE)
                next_st.rdata = st.test_en;
            else if (bus_i.addr[7:0] == `DSPRC_OFS_MEMORY_PAGE)
                next_st.rdata = st.page;
        end
        else if (rd_act && |fsel)
        begin
            // busy reads give inverted poll bit and a toggle per read
            if (st.fl_st == FL_BUSY_PROG || st.fl_st == FL_BUSY_ERASE)
            begin
                next_st.rdata[`DSPRC_STAT_POLL_BIT] = st.fl_st == FL_BUSY_ERASE ? 1'b0
                    : ~st.prog_data[`DSPRC_STAT_POLL_BIT];
                next_st.rdata[`DSPRC_STAT_TOGGLE_BIT] = st.toggle;
                next_st.toggle = ~st.toggle;
            end
            else if (st.fl_st == FL_ID)
                next_st.rdata = lo[1:0] == 2'b10
                    ? {7'h00, sector_protect_i[fl_addr[16:14]]} : FLASH_ID;
            else
                next_st.rdata = mem_rd;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register: everything clears on reset except wr_q, which is set

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            st <= '0;
            st.wr_q <= 1'b1;
            st.fl_st <= FL_READ;
        end
        else
            st <= next_st;
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    // open drain releases the pin whenever the output bit is high
    assign pb_o = '{out: st.pb_out, drive_sel: st.pb_ds,
        oe_n: ~(st.pb_dir & ~(st.pb_ds & st.pb_out))};
    assign pc_o = '{out: st.pc_out, drive_sel: st.pc_ds,
        oe_n: ~(st.pc_dir & ~(st.pc_ds & st.pc_out))};
    assign pd_o = '{out: st.pd_out, drive_sel: st.pd_ds,
        oe_n: ~(st.pd_dir & ~(st.pd_ds & st.pd_out))};
    assign output_cell_ab_o = st.cells_ab;
    assign output_cell_bc_o = st.cells_bc;
    assign power_control_0_o = st.pm0;
    assign power_control_2_o = st.pm2;
    assign test_port_pin_enable_o = st.test_en[0];
    assign ready_busy_pin_o = !(st.fl_st == FL_BUSY_PROG
        || st.fl_st == FL_BUSY_ERASE);
    assign rdata_o = st.rdata;
    assign rdata_oe_o = st.rd_valid;

endmodule : dsprc_top

// [test/dsprc_top_sva.sv]
// dsprc_top_sva.sv: port checks of the runtime control block
// assumes binding into dsprc_top; one clock, rst_i synchronous active high
module dsprc_chk
    import dsprc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire dsprc_pkg::dsprc_bus_t bus_i,
    input wire logic [7:0] rdata_o,
    input wire logic rdata_oe_o,
    input wire logic [7:0] pb_pins_i,
    input wire logic secured_i,
    input wire dsprc_pkg::dsprc_port_t pb_o,
    input wire logic test_port_pin_enable_o,
    input wire logic [7:0] flash_sector_selects_o,
    input wire logic ready_busy_pin_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // control read: i/o strobe alone, offset inside the low 256
    sequence s_rd(a);
        !bus_i.rd_n && !bus_i.ioms_n && bus_i.dms_n && bus_i.bms_n && bus_i.addr == {10'h000, a};
    endsequence
    property p_sel; s_rd(bus_i.addr[7:0]) |=> rdata_oe_o; endproperty
    a_sel: assert property (p_sel) else $error("no answer");
    property p_idle; bus_i.rd_n |=> !rdata_oe_o; endproperty
    a_idle: assert property (p_idle) else $error("stray answer");
    property p_pin; s_rd(8'h01) |=> rdata_o == $past(pb_pins_i); endproperty
    a_pin: assert property (p_pin) else $error("pin read");
    property p_sec; s_rd(8'hc2) |=> rdata_o == {7'h00, $past(secured_i)}; endproperty
    a_sec: assert property (p_sec) else $error("secure read");
    // first edge after release still shows the cleared state
    property p_rst; $fell(rst_i) |-> ready_busy_pin_o && !rdata_oe_o && pb_o.oe_n == 8'hff;
    endproperty
    a_rst: assert property (p_rst) else $error("reset state");
    property p_out; !$stable(pb_o.out) |-> $past(!bus_i.wr_n && bus_i.addr[7:0] == 8'h05);
    endproperty
    a_out: assert property (p_out) else $error("pin level moved");
    property p_tpe; !$stable(test_port_pin_enable_o) |->
        $past(!bus_i.wr_n && bus_i.addr[7:0] == 8'hc7); endproperty
    a_tpe: assert property (p_tpe) else $error("test enable moved");
    property p_fs; !bus_i.bms_n && bus_i.ioms_n && bus_i.dms_n && !bus_i.addr[17] |->
        flash_sector_selects_o == 8'h01 << bus_i.addr[16:14]; endproperty
    a_fs: assert property (p_fs) else $error("sector select");
endmodule : dsprc_chk
bind dsprc_top dsprc_chk u_dsprc_chk (.clk_i, .rst_i, .bus_i, .rdata_o, .rdata_oe_o, .pb_pins_i,
    .secured_i, .pb_o, .test_port_pin_enable_o, .flash_sector_selects_o, .ready_busy_pin_o);

// [test/dsprc_dsp_model.sv]
// dsprc_dsp_model.sv: processor bus master making byte accesses
// assumes strobes are sampled at rising clk_i and answered a cycle later
module dsprc_dsp_model
    import dsprc_pkg::*;
(
    input wire logic clk_i,
    input wire logic [7:0] rdata_i,
    input wire logic rdata_oe_i,
    output dsprc_pkg::dsprc_bus_t bus_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial bus_o = '{addr: '0, wdata: '0, default: '1};
    // one byte in space s = {ioms_n, dms_n, bms_n}; upper byte is junk
    task automatic acc(input logic w, input logic [2:0] s, input logic [17:0] a,
        input logic [7:0] d, output logic [8:0] q);
        @(posedge clk_i);
        bus_o <= '{addr: a, wdata: {~d, d}, rd_n: w, wr_n: !w, ioms_n: s[2], dms_n: s[1],
            bms_n: s[0]};
        @(posedge clk_i);
        // released lines flip so a stale value never reads as valid
        bus_o <= '{addr: ~a, wdata: {d, ~d}, default: '1};
        #1 q = {rdata_oe_i, rdata_i};
    endtask : acc
endmodule : dsprc_dsp_model

// [test/tb_top.sv]
// tb_top.sv: self-checking bench of the runtime control block
// assumes the design, its checker and the processor model compile first
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import dsprc_pkg::*;
    localparam logic [7:0] RW [17] = '{8'h05, 8'h07, 8'h09, 8'h12, 8'h13, 8'h14, 8'h15,
        8'h16, 8'h17, 8'h20, 8'h21, 8'h22, 8'h23, 8'hb0, 8'hb4, 8'hc7, 8'he0};
    localparam logic [7:0] RO [7] = '{8'h01, 8'h10, 8'h11, 8'h0b, 8'h18, 8'hc0, 8'hc2};
    logic clk_i = 0;
    logic rst_i = 1;
    logic [7:0] rx [7] = '{default: 8'h00};
    logic [7:0] wv [17];
    logic [7:0] rd, ocab, pm0;
    logic oe, tpe, rdy;
    logic [8:0] q;
    dsprc_bus_t bus;
    dsprc_port_t pbo;
    int err_count = 0;
    int tests_run = 0;
    int cyc = 0;
    dsprc_top #(.PROG_CYCLES(4), .ERASE_WINDOW_CYCLES(8)) u_dsprc_top (.clk_i, .rst_i,
        .bus_i(bus), .rdata_o(rd), .rdata_oe_o(oe), .pb_pins_i(rx[0]), .pc_pins_i(rx[1]),
        .pd_pins_i(rx[2]), .pb_o(pbo), .pc_o(), .pd_o(), .input_cell_b_i(rx[3]),
        .input_cell_c_i(rx[4]), .output_cell_ab_o(ocab), .output_cell_bc_o(),
        .sector_protect_i(rx[5]), .secured_i(rx[6][0]), .power_control_0_o(pm0),
        .power_control_2_o(), .test_port_pin_enable_o(tpe), .flash_sector_selects_o(),
        .ready_busy_pin_o(rdy));
    dsprc_dsp_model u_dsprc_dsp_model (.clk_i, .rdata_i(rd), .rdata_oe_i(oe), .bus_o(bus));
    initial forever #12.5 clk_i = ~clk_i;
    task automatic chk(input string n, input logic [8:0] e, input logic [8:0] g);
        tests_run++;
        if (g !== e)
        begin
            err_count++;
            $display("CHECK FAILED %s exp %h got %h", n, e, g);
        end
    endtask : chk
    task automatic io(input logic w, input logic [7:0] a, input logic [7:0] d);
        u_dsprc_dsp_model.acc(w, 3'b011, {10'h000, a}, d, q);
    endtask : io
    // command bytes go to sector one in dma space
    task automatic fl(input logic [11:0] a, input logic [7:0] d);
        u_dsprc_dsp_model.acc(1'b1, 3'b110, {6'h04, a}, d, q);
    endtask : fl
    // open-drain bits release on a one, so they do not count as driven
    function automatic logic [7:0] en();
        return wv[1] & ~(wv[2] & wv[0]);
    endfunction : en
    task automatic end_sim();
        $display("tests_run %0d err_count %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : end_sim
    // the whole run needs well under a thousand cycles
    always @(posedge clk_i)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            err_count++;
            end_sim();
        end
    end
    initial
    begin
        void'($urandom(32'h66e8_cf26));
        repeat (8) @(posedge clk_i);
        rst_i <= 0;
        foreach (RW[i])
        begin
            wv[i] = 8'($urandom());
            io(0, RW[i], 0);
            chk("reset", 9'h100, q);
            io(1, RW[i], wv[i]);
            io(0, RW[i], 0);
            chk("rw", {1'b1, wv[i]}, q);
        end
        chk("pm0", {1'b0, wv[13]}, {1'b0, pm0});
        chk("tpe", {8'h00, wv[15][0]}, {8'h00, tpe});
        io(0, 8'h0d, 0);
        chk("oe", {1'b1, en()}, q);
        chk("oe_n", {1'b0, ~en()}, {1'b0, pbo.oe_n});
        @(posedge clk_i);
        foreach (rx[i]) rx[i] <= 8'($urandom() >> (i == 6 ? 31 : 0));
        foreach (RO[i])
        begin
            io(1, RO[i], 8'($urandom()));
            io(0, RO[i], 0);
            chk("ro", {1'b1, rx[i]}, q);
        end
        io(0, 8'h03, 0);
        chk("unused", 9'h100, q);
        u_dsprc_dsp_model.acc(1'b0, 3'b011, 18'h0_0101, 8'h00, q);
        chk("above", 9'h000, q);
        io(1, 8'h22, 8'hff);
        io(1, 8'h20, ~wv[9]);
        io(0, 8'h20, 0);
        chk("mask", 9'h100, q);
        chk("cell", {1'b0, wv[9]}, {1'b0, ocab});
        $display("test registers done");
        for (int p = 1; p >= 0; p--)
        begin
            @(posedge clk_i);
            rx[5] <= {6'h00, p[0], 1'b0};
            fl(12'h555, 8'haa);
            fl(12'haaa, 8'h55);
            fl(12'h555, 8'ha0);
            fl(12'h123, 8'h3c);
            chk("busy", {8'h00, p[0]}, {8'h00, rdy});
            repeat (8) @(posedge clk_i);
            #1 chk("ready", 9'h001, {8'h00, rdy});
        end
        $display("test flash done");
        end_sim();
    end
endmodule : tb_top
